// >>> core/flash_self_program_guard.sv
// Purpose: Mode strap capture, write protect and interrupt redirection.
// Assumes: CPU sequencer reports self status and flash requests directly.
// Notes: All outputs are registered; all but op_mode take one cycle of latency, op_mode follows the third edge after release.
`timescale 1ns/1ps
module flash_self_program_guard
  import flash_guard_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flash_mode_protect_pin,
  input wire logic aux_mode_select_pin,
  input wire logic self_prog_active,
  input wire logic flash_erase_req,
  input wire logic flash_write_req,
  input wire logic irq_maskable,
  input wire logic irq_nmi,
  input wire logic fetch_req,
  input wire logic fetch_is_flash,
  output op_mode_t op_mode,
  output logic flash_erase_go,
  output logic flash_write_go,
  output logic flash_req_dropped,
  output logic irq_take,
  output logic [31:0] irq_vector,
  output logic fetch_grant,
  output logic fetch_blocked
);
  logic protect_sync;
  logic aux_sync;
  logic strap_pending_q;
  op_mode_t mode_q;
  op_mode_t mode_d;
  logic erase_go_q;
  logic write_go_q;
  logic dropped_q;
  logic irq_take_q;
  logic [31:0] vec_q;
  logic fetch_grant_q;
  logic fetch_blocked_q;

  pin_sync u_protect_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(flash_mode_protect_pin),
    .pin_out(protect_sync)
  );

  pin_sync u_aux_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(aux_mode_select_pin),
    .pin_out(aux_sync)
  );

  // The strap is caught once the synchroniser has refilled after release,
  // so the captured level is the pin as it stood at the release.
  logic [1:0] strap_cnt_q;
  wire strap_take = strap_pending_q && (strap_cnt_q == 2'(SYNC_STAGES));

  always_comb begin
    if (!protect_sync) mode_d = MODE_NORMAL;
    else if (!aux_sync) mode_d = MODE_PROGRAMMING;
    else mode_d = MODE_PROHIBITED;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_pending_q <= 1'b1;
      strap_cnt_q <= 2'h0;
      mode_q <= MODE_NORMAL;
    end else if (strap_pending_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_take) begin
        strap_pending_q <= 1'b0;
        mode_q <= mode_d;
      end
    end
  end

  // Writes pass only with the pin high in self status; everything else
  // is dropped and flash stays untouched.
  wire wr_allowed = self_prog_active && protect_sync;
  wire any_req = flash_erase_req || flash_write_req;
  wire drop = any_req && !wr_allowed;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      erase_go_q <= 1'b0;
      write_go_q <= 1'b0;
      dropped_q <= 1'b0;
    end else begin
      erase_go_q <= flash_erase_req && wr_allowed;
      write_go_q <= flash_write_req && wr_allowed;
      dropped_q <= drop;
    end
  end

  // NMI outranks a maskable request in the same cycle.
  wire irq_any = irq_nmi || irq_maskable;
  wire [31:0] self_vec = irq_nmi ? RAM_NMI_VEC : RAM_MASKABLE_VEC;
  wire [31:0] norm_vec = irq_nmi ? FLASH_NMI_VEC : FLASH_MASKABLE_VEC;
  wire [31:0] vec_d = self_prog_active ? self_vec : norm_vec;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_take_q <= 1'b0;
      vec_q <= 32'h00000000;
    end else begin
      irq_take_q <= irq_any;
      vec_q <= irq_any ? vec_d : vec_q;
    end
  end

  wire fetch_stop = fetch_req && fetch_is_flash && self_prog_active;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_grant_q <= 1'b0;
      fetch_blocked_q <= 1'b0;
    end else begin
      fetch_grant_q <= fetch_req && !fetch_stop;
      fetch_blocked_q <= fetch_stop;
    end
  end

  assign op_mode = mode_q;
  assign flash_erase_go = erase_go_q;
  assign flash_write_go = write_go_q;
  assign flash_req_dropped = dropped_q;
  assign irq_take = irq_take_q;
  assign irq_vector = vec_q;
  assign fetch_grant = fetch_grant_q;
  assign fetch_blocked = fetch_blocked_q;

  AST_NO_WRITE_PROT_LOW: assert property (
    @(posedge clk) disable iff (sys_rst)
    (flash_write_req && !protect_sync) |=> !flash_write_go)
    else $error("Write passed with protect pin low.");

  AST_NO_ERASE_PROT_LOW: assert property (
    @(posedge clk) disable iff (sys_rst)
    (flash_erase_req && !protect_sync) |=> !flash_erase_go)
    else $error("Erase passed with protect pin low.");

  AST_DROP_FLAG: assert property (
    @(posedge clk) disable iff (sys_rst)
    (any_req && !protect_sync) |=> flash_req_dropped)
    else $error("Dropped request not flagged.");

  // Outside self status every request is refused, whatever the pin does.
  AST_NO_GO_OUT_OF_SELF: assert property (
    @(posedge clk) disable iff (sys_rst)
    (any_req && !self_prog_active) |=>
      (!flash_write_go && !flash_erase_go && flash_req_dropped))
    else $error("Request passed outside self programming status.");

  AST_WRITE_PASSES: assert property (
    @(posedge clk) disable iff (sys_rst)
    (flash_write_req && self_prog_active && protect_sync) |=>
      (flash_write_go && !flash_req_dropped))
    else $error("Allowed write did not pass.");

  AST_ERASE_PASSES: assert property (
    @(posedge clk) disable iff (sys_rst)
    (flash_erase_req && self_prog_active && protect_sync) |=>
      (flash_erase_go && !flash_req_dropped))
    else $error("Allowed erase did not pass.");

  AST_NMI_VEC: assert property (
    @(posedge clk) disable iff (sys_rst)
    (irq_nmi && self_prog_active) |=>
      (irq_take && irq_vector == RAM_NMI_VEC))
    else $error("NMI not sent to RAM start.");

  AST_MASK_VEC: assert property (
    @(posedge clk) disable iff (sys_rst)
    (irq_maskable && !irq_nmi && self_prog_active) |=>
      (irq_take && irq_vector == RAM_MASKABLE_VEC))
    else $error("Maskable interrupt not sent to RAM start plus four.");

  // Normal status keeps the flash vectors, so handlers in flash still run.
  AST_NORM_NMI_VEC: assert property (
    @(posedge clk) disable iff (sys_rst)
    (irq_nmi && !self_prog_active) |=>
      (irq_take && irq_vector == FLASH_NMI_VEC))
    else $error("NMI in normal status not sent to the flash vector.");

  AST_NORM_MASK_VEC: assert property (
    @(posedge clk) disable iff (sys_rst)
    (irq_maskable && !irq_nmi && !self_prog_active) |=>
      (irq_take && irq_vector == FLASH_MASKABLE_VEC))
    else $error("Maskable interrupt in normal status misdirected.");

  AST_IRQ_TAKEN: assert property (
    @(posedge clk) disable iff (sys_rst)
    irq_any |=> irq_take)
    else $error("Interrupt not taken.");

  AST_NO_FLASH_FETCH: assert property (
    @(posedge clk) disable iff (sys_rst)
    (fetch_req && fetch_is_flash && self_prog_active) |=>
      (!fetch_grant && fetch_blocked))
    else $error("Flash fetch granted during self programming.");

  // Blocking must not spill onto fetches from RAM or outside self status.
  AST_FETCH_GRANT: assert property (
    @(posedge clk) disable iff (sys_rst)
    (fetch_req && !(fetch_is_flash && self_prog_active)) |=>
      (fetch_grant && !fetch_blocked))
    else $error("Allowed fetch was not granted.");

  AST_MODE_STABLE: assert property (
    @(posedge clk) disable iff (sys_rst)
    !strap_pending_q |=> $stable(op_mode))
    else $error("Operation mode changed after strap capture.");

  AST_MODE_PIN_LOW: assert property (
    @(posedge clk) disable iff (sys_rst)
    (strap_take && !protect_sync) |=> op_mode == MODE_NORMAL)
    else $error("Pin low at release did not give normal mode.");

  AST_PROG_NEEDS_AUX_LOW: assert property (
    @(posedge clk) disable iff (sys_rst)
    (strap_take && aux_sync) |=> op_mode != MODE_PROGRAMMING)
    else $error("Programming mode entered with aux pin high.");

  AST_PROG_ON_AUX_LOW: assert property (
    @(posedge clk) disable iff (sys_rst)
    (strap_take && protect_sync && !aux_sync) |=>
      op_mode == MODE_PROGRAMMING)
    else $error("Programming mode not entered with aux pin low.");

  COV_WRITE_GO: cover property (@(posedge clk) disable iff (sys_rst)
    flash_write_go);
  COV_DROP: cover property (@(posedge clk) disable iff (sys_rst)
    flash_req_dropped);
  COV_SELF_NMI: cover property (@(posedge clk) disable iff (sys_rst)
    irq_take && irq_vector == RAM_NMI_VEC);
  COV_PROG_MODE: cover property (@(posedge clk) disable iff (sys_rst)
    op_mode == MODE_PROGRAMMING);
  COV_SELF_MASK: cover property (@(posedge clk) disable iff (sys_rst)
    irq_take && irq_vector == RAM_MASKABLE_VEC);
endmodule // flash_self_program_guard

// >>> include/flash_guard_pkg.sv
// Purpose: Constants for the flash self-programming guard.
// Assumes: One 250 MHz clock, synchronous active-high reset.
// Notes: Addresses are CPU byte addresses; vectors are 32 bits wide.
//
// Operation
// - The mode/protect pin level caught at reset release picks the mode.
// - Flash writes during self-rewriting are blocked unless the pin is high.
// - Maskable and NMI interrupts are taken in both normal and self status.
// - In self status a maskable interrupt goes to RAM start plus four.
// - In self status an NMI goes to the RAM start address.
// - No instruction is fetched from flash while self-programming runs.
// - Programming mode is entered only if the aux pin is low at release.
package flash_guard_pkg;
  localparam logic [31:0] RAM_NMI_VEC = 32'h03ffb000;
  localparam logic [31:0] RAM_MASKABLE_VEC = 32'h03ffb004;
  localparam logic [31:0] FLASH_NMI_VEC = 32'h00000010;
  localparam logic [31:0] FLASH_MASKABLE_VEC = 32'h00000080;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PROGRAMMING = 2'b01,
    MODE_PROHIBITED = 2'b10
  } op_mode_t;
endpackage

// >>> core/pin_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous pin.
// Assumes: Pin is a slow level.
// Notes: Stage one is read only by stage two.
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic pin_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_out = sync_q;
endmodule // pin_sync

// >>> tb/flash_self_program_guard_test.sv
// Purpose: Self-checking bench for the flash self-programming guard.
// Assumes: Pins change only while no request is pending, then settle.
// Notes: The model predicts each output one cycle after its request.
`timescale 1ns/1ps
module flash_self_program_guard_test;
  import flash_guard_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pin = 1'b0, aux = 1'b0, slf = 1'b0, er = 1'b0, wr = 1'b0;
  logic im = 1'b0, nm = 1'b0, fr = 1'b0, ff = 1'b0;
  op_mode_t op_mode, exp_mode;
  logic erase_go, write_go, dropped, irq_take, grant, blocked;
  logic [31:0] irq_vector, exp_vec;
  int error_cnt = 0;
  int samples_checked = 0;

  always #2 clk = ~clk;

  flash_self_program_guard uut (
    .clk(clk), .sys_rst(sys_rst), .flash_mode_protect_pin(pin),
    .aux_mode_select_pin(aux), .self_prog_active(slf),
    .flash_erase_req(er), .flash_write_req(wr), .irq_maskable(im),
    .irq_nmi(nm), .fetch_req(fr), .fetch_is_flash(ff), .op_mode(op_mode),
    .flash_erase_go(erase_go), .flash_write_go(write_go),
    .flash_req_dropped(dropped), .irq_take(irq_take),
    .irq_vector(irq_vector), .fetch_grant(grant), .fetch_blocked(blocked)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Inputs held since the last edge are what the design samples next.
  task automatic step(input bit rnd);
    logic s, e, w, m, n, q, f, ok;
    s = slf;
    e = er;
    w = wr;
    m = im;
    n = nm;
    q = fr;
    f = ff;
    @(posedge clk);
    slf <= rnd & 1'($urandom());
    er <= rnd & 1'($urandom());
    wr <= rnd & 1'($urandom());
    im <= rnd & 1'($urandom());
    nm <= rnd & 1'($urandom());
    fr <= rnd & 1'($urandom());
    ff <= rnd & 1'($urandom());
    @(negedge clk);
    ok = s & pin;
    if (m | n)
      exp_vec = n ? (s ? RAM_NMI_VEC : FLASH_NMI_VEC) :
                (s ? RAM_MASKABLE_VEC : FLASH_MASKABLE_VEC);
    check("op_mode", op_mode, exp_mode);
    check("erase_go", erase_go, e & ok);
    check("write_go", write_go, w & ok);
    check("dropped", dropped, (e | w) & !ok);
    check("irq_take", irq_take, m | n);
    check("irq_vector", irq_vector, exp_vec);
    check("fetch_grant", grant, q & !(s & f));
    check("fetch_blocked", blocked, q & s & f);
  endtask

  // The strap is set in the same cycle that reset is asserted and held, as the board would hold it.
  task automatic do_reset(input logic p, input logic a, input op_mode_t m);
    @(posedge clk);
    sys_rst <= 1'b1;
    pin <= p;
    aux <= a;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    exp_vec = 32'h0;
    // The strap reaches op_mode only on the third edge after release.
    exp_mode = MODE_NORMAL;
    repeat (2) step(1'b0);
    exp_mode = m;
    repeat (4) step(1'b0);
    repeat (60) step(1'b1);
    step(1'b0);
  endtask

  task automatic set_pin(input logic p);
    @(posedge clk);
    pin <= p;
    repeat (4) step(1'b0);
  endtask

  initial begin
    void'($urandom(32'hc49b98e3));
    // RAM jumps, entry area, stack, code placement and the reserved timers
    // are the program's side and never reach these pins.
    // The same holds for library placement and timer use.
    do_reset(1'b1, 1'b1, MODE_PROHIBITED);
    do_reset(1'b1, 1'b0, MODE_PROGRAMMING);
    do_reset(1'b0, 1'b1, MODE_NORMAL);
    do_reset(1'b0, 1'b0, MODE_NORMAL);
    repeat (150) step(1'b1);
    step(1'b0);
    set_pin(1'b1);
    repeat (300) step(1'b1);
    step(1'b0);
    set_pin(1'b0);
    repeat (100) step(1'b1);
    step(1'b0);
    complete_run();
  end
endmodule // flash_self_program_guard_test
